// [logic/iosm_pkg.sv]
/*
 * iosm_pkg: constants and state types for the port status mapper and
 * diagnostics record builder.
 * assumes: eight ports, byte-wide images, 34-byte record sent byte-serially.
 */
`default_nettype none
package iosm_pkg;
	localparam int unsigned NPORT       = 8;
	localparam int unsigned REC_LEN     = 34;
	localparam int unsigned HDR_LEN     = 24;
	localparam logic [5:0]  REC_LAST    = 6'h21;
	localparam logic [15:0] BLK_TYPE    = 16'h0002;
	localparam logic [15:0] BLK_LEN     = 16'h001e;
	localparam logic [7:0]  VER_HI      = 8'h01;
	localparam logic [7:0]  VER_LO      = 8'h00;
	localparam logic [15:0] ALARM_TYPE  = 16'h0001;
	localparam logic [31:0] API_VAL     = 32'h0000_0000;
	localparam logic [15:0] USER_STRUCT = 16'h8000;
	// station diagnostics bit positions
	localparam int unsigned SD_LINK_SHORT = 7;
	localparam int unsigned SD_ACT_WARN   = 6;
	localparam int unsigned SD_ACT_SHORT  = 5;
	localparam int unsigned SD_SENS_SHORT = 4;
	localparam int unsigned SD_EXT_ERR    = 3;
	localparam int unsigned SD_ACT_SUPPLY = 1;
	localparam int unsigned SD_SENS_SUPPLY = 0;

	typedef enum logic [1:0] {
		IOSM_IDLE = 2'b01,
		IOSM_SEND = 2'b10
	} iosm_state_t;

	typedef struct packed {
		logic [7:0]  in_img_p4;
		logic [7:0]  in_img_p2;
		logic [7:0]  out_img_p4;
		logic [7:0]  out_img_p2;
		logic [7:0]  shut_p4;
		logic [7:0]  shut_p2;
		logic [7:0]  warn_p4;
		logic [7:0]  warn_p2;
		logic [7:0]  perr;
		logic [7:0]  stn;
		logic [7:0]  perr_seen;
		logic        pending;
		iosm_state_t st;
		logic [5:0]  idx;
		logic [7:0]  byte_out;
		logic [15:0] chan;
	} iosm_regs_t;
endpackage : iosm_pkg
`default_nettype wire

// [logic/iosm_top.sv]
/*
 * iosm_top: maps per-port input, output and fault states into byte images
 * and builds the 34-byte diagnostics record when new port errors appear, one record for all that arrive before it starts.
 * assumes: all inputs synchronous to mclk; slot, subslot, module id, alarm
 * specifier, channel properties and error type are steady while a record
 * is being read; the reader takes bytes with rec_ready.
 */
`timescale 1ns/1ns
`default_nettype none
module iosm_top (
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  in_p4,
	input  wire logic [7:0]  in_p2,
	input  wire logic [7:0]  diag_in_p2,
	input  wire logic [7:0]  diag_in_en,
	input  wire logic [7:0]  out_cmd_p4,
	input  wire logic [7:0]  out_cmd_p2,
	input  wire logic [7:0]  short_gnd_p4,
	input  wire logic [7:0]  short_gnd_p2,
	input  wire logic [7:0]  volt_fb_p4,
	input  wire logic [7:0]  volt_fb_p2,
	input  wire logic        manual_restart,
	input  wire logic [7:0]  restart_p4,
	input  wire logic [7:0]  restart_p2,
	input  wire logic [7:0]  sensor_short,
	input  wire logic        link_short,
	input  wire logic        ext_error,
	input  wire logic        actuator_supply_fault,
	input  wire logic        sensor_supply_fault,
	input  wire logic [15:0] slot_num,
	input  wire logic [15:0] subslot_num,
	input  wire logic [63:0] module_id,
	input  wire logic [15:0] alarm_spec,
	input  wire logic [15:0] chan_props,
	input  wire logic [15:0] chan_err_type,
	input  wire logic        rec_ready,
	output logic [7:0]       in_img_p4,
	output logic [7:0]       in_img_p2,
	output logic [7:0]       out_img_p4,
	output logic [7:0]       out_img_p2,
	output logic [7:0]       drive_p4,
	output logic [7:0]       drive_p2,
	output logic [7:0]       shutdown_p4,
	output logic [7:0]       shutdown_p2,
	output logic [7:0]       warning_p4,
	output logic [7:0]       warning_p2,
	output logic [7:0]       periph_err,
	output logic [7:0]       station_diag,
	output logic             rec_pending,
	output logic             rec_valid,
	output logic [7:0]       rec_byte,
	output logic             rec_last
);
	iosm_pkg::iosm_regs_t r_q;
	iosm_pkg::iosm_regs_t r_d;

	// ----------------------------------------------------------------
	// record byte lookup
	// ----------------------------------------------------------------
	function automatic logic [7:0] rec_at(input logic [5:0] i, input logic [15:0] ch);
		logic [7:0] b;
		b = 8'h00;
		unique case (i)
			6'h00: b = iosm_pkg::BLK_TYPE[15:8];
			6'h01: b = iosm_pkg::BLK_TYPE[7:0];
			6'h02: b = iosm_pkg::BLK_LEN[15:8];
			6'h03: b = iosm_pkg::BLK_LEN[7:0];
			6'h04: b = iosm_pkg::VER_HI;
			6'h05: b = iosm_pkg::VER_LO;
			6'h06: b = iosm_pkg::ALARM_TYPE[15:8];
			6'h07: b = iosm_pkg::ALARM_TYPE[7:0];
			6'h08: b = iosm_pkg::API_VAL[31:24];
			6'h09: b = iosm_pkg::API_VAL[23:16];
			6'h0a: b = iosm_pkg::API_VAL[15:8];
			6'h0b: b = iosm_pkg::API_VAL[7:0];
			6'h0c: b = slot_num[15:8];
			6'h0d: b = slot_num[7:0];
			6'h0e: b = subslot_num[15:8];
			6'h0f: b = subslot_num[7:0];
			6'h10: b = module_id[63:56];
			6'h11: b = module_id[55:48];
			6'h12: b = module_id[47:40];
			6'h13: b = module_id[39:32];
			6'h14: b = module_id[31:24];
			6'h15: b = module_id[23:16];
			6'h16: b = module_id[15:8];
			6'h17: b = module_id[7:0];
			6'h18: b = alarm_spec[15:8];
			6'h19: b = alarm_spec[7:0];
			6'h1a: b = iosm_pkg::USER_STRUCT[15:8];
			6'h1b: b = iosm_pkg::USER_STRUCT[7:0];
			6'h1c: b = ch[15:8];
			6'h1d: b = ch[7:0];
			6'h1e: b = chan_props[15:8];
			6'h1f: b = chan_props[7:0];
			6'h20: b = chan_err_type[15:8];
			6'h21: b = chan_err_type[7:0];
			default: b = 8'h00;
		endcase
		return b;
	endfunction : rec_at

	function automatic logic [15:0] low_port(input logic [7:0] v);
		logic [15:0] n;
		n = 16'h0000;
		for (int k = iosm_pkg::NPORT - 1; k >= 0; k--)
			if (v[k])
				n = 16'(k);
		return n;
	endfunction : low_port

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic [7:0] err_now;
	logic       new_err;
	logic       take;

	always_comb
	begin
		r_d = r_q;
		r_d.in_img_p4  = in_p4;
		r_d.in_img_p2  = (in_p2 & ~diag_in_en) | (diag_in_p2 & diag_in_en);
		r_d.out_img_p4 = out_cmd_p4;
		r_d.out_img_p2 = out_cmd_p2;
		// shutdown latches; auto restart once the short is gone, else wait for restart bit
		r_d.shut_p4 = (r_q.shut_p4 | (out_cmd_p4 & short_gnd_p4))
			& ~(~short_gnd_p4 & (manual_restart ? restart_p4 : 8'hff));
		r_d.shut_p2 = (r_q.shut_p2 | (out_cmd_p2 & short_gnd_p2))
			& ~(~short_gnd_p2 & (manual_restart ? restart_p2 : 8'hff));
		r_d.warn_p4 = volt_fb_p4 & ~out_cmd_p4;
		r_d.warn_p2 = volt_fb_p2 & ~out_cmd_p2;
		err_now = r_d.shut_p4 | r_d.shut_p2 | r_d.warn_p4 | r_d.warn_p2 | sensor_short;
		r_d.perr = err_now;
		r_d.stn = 8'h00;
		r_d.stn[iosm_pkg::SD_LINK_SHORT]  = link_short;
		r_d.stn[iosm_pkg::SD_ACT_WARN]    = |(r_d.warn_p4 | r_d.warn_p2);
		r_d.stn[iosm_pkg::SD_ACT_SHORT]   = |(r_d.shut_p4 | r_d.shut_p2);
		r_d.stn[iosm_pkg::SD_SENS_SHORT]  = |sensor_short;
		r_d.stn[iosm_pkg::SD_EXT_ERR]     = ext_error;
		r_d.stn[iosm_pkg::SD_ACT_SUPPLY]  = actuator_supply_fault;
		r_d.stn[iosm_pkg::SD_SENS_SUPPLY] = sensor_supply_fault;
		new_err = |(err_now & ~r_q.perr_seen);
		r_d.perr_seen = err_now;
		take = (r_q.st == iosm_pkg::IOSM_SEND) && rec_ready;
		unique case (r_q.st)
			iosm_pkg::IOSM_IDLE:
			begin
				if (r_q.pending)
				begin
					r_d.st       = iosm_pkg::IOSM_SEND;
					r_d.pending  = 1'b0;
					r_d.idx      = 6'h00;
					r_d.chan     = low_port(r_q.perr);
					r_d.byte_out = rec_at(6'h00, r_d.chan);
				end
			end
			iosm_pkg::IOSM_SEND:
			begin
				if (take)
				begin
					if (r_q.idx == iosm_pkg::REC_LAST)
						r_d.st = iosm_pkg::IOSM_IDLE;
					else
					begin
						r_d.idx      = r_q.idx + 6'h01;
						r_d.byte_out = rec_at(r_d.idx, r_q.chan);
					end
				end
			end
			default: r_d.st = iosm_pkg::IOSM_IDLE;
		endcase
		// set wins over the clear taken at record start
		if (new_err)
			r_d.pending = 1'b1;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			r_q    <= '0;
			r_q.st <= iosm_pkg::IOSM_IDLE;
		end
		else
			r_q <= r_d;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign in_img_p4    = r_q.in_img_p4;
	assign in_img_p2    = r_q.in_img_p2;
	assign out_img_p4   = r_q.out_img_p4;
	assign out_img_p2   = r_q.out_img_p2;
	assign drive_p4     = r_q.out_img_p4 & ~r_q.shut_p4;
	assign drive_p2     = r_q.out_img_p2 & ~r_q.shut_p2;
	assign shutdown_p4  = r_q.shut_p4;
	assign shutdown_p2  = r_q.shut_p2;
	assign warning_p4   = r_q.warn_p4;
	assign warning_p2   = r_q.warn_p2;
	assign periph_err   = r_q.perr;
	assign station_diag = r_q.stn;
	assign rec_pending  = r_q.pending;
	assign rec_valid    = (r_q.st == iosm_pkg::IOSM_SEND);
	assign rec_byte     = r_q.byte_out;
	assign rec_last     = rec_valid && (r_q.idx == iosm_pkg::REC_LAST);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [5:0] beats_q;
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			beats_q <= 6'h00;
		else if (!rec_valid)
			beats_q <= 6'h00;
		else if (rec_ready)
			beats_q <= beats_q + 6'h01;
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);

	sequence s_rec_start;
		!rec_valid ##1 rec_valid;
	endsequence

	chk_image_map: assert property (##1 in_img_p4 == $past(in_p4)) else $error("pin4 input image wrong");
	chk_diag_input: assert property (
		##1 in_img_p2 == (($past(in_p2) & ~$past(diag_in_en)) | ($past(diag_in_p2) & $past(diag_in_en))))
		else $error("pin2 diag image wrong");
	chk_short_sets: assert property (
		(out_cmd_p4 & short_gnd_p4) != 8'h00
		|=> (shutdown_p4 & $past(out_cmd_p4) & $past(short_gnd_p4)) == ($past(out_cmd_p4) & $past(short_gnd_p4)))
		else $error("pin4 shutdown not set");
	chk_short_sets_p2: assert property (
		(out_cmd_p2 & short_gnd_p2) != 8'h00
		|=> (shutdown_p2 & $past(out_cmd_p2) & $past(short_gnd_p2)) == ($past(out_cmd_p2) & $past(short_gnd_p2)))
		else $error("pin2 shutdown not set");
	chk_warn_sets: assert property (
		##1 warning_p2 == ($past(volt_fb_p2) & ~$past(out_cmd_p2))
		&& warning_p4 == ($past(volt_fb_p4) & ~$past(out_cmd_p4)))
		else $error("warning wrong");
	chk_manual_hold: assert property (
		(manual_restart && (shutdown_p4 & ~restart_p4) != 8'h00)
		|=> (shutdown_p4 & $past(shutdown_p4) & ~$past(restart_p4)) == ($past(shutdown_p4) & ~$past(restart_p4))
		&& (drive_p4 & $past(shutdown_p4) & ~$past(restart_p4)) == 8'h00)
		else $error("auto restart under manual");
	chk_perr_or: assert property (
		periph_err == (shutdown_p4 | shutdown_p2 | warning_p4 | warning_p2 | $past(sensor_short)))
		else $error("periph error wrong");
	chk_pending_go: assert property ((rec_pending && !rec_valid) |=> rec_valid) else $error("record not started");
	chk_rec_length: assert property (
		(rec_valid && rec_ready) |-> ((beats_q == iosm_pkg::REC_LAST) == rec_last))
		else $error("record length not 34");
	chk_hdr_start: assert property (
		s_rec_start |-> rec_byte == iosm_pkg::BLK_TYPE[15:8]
		##0 (!rec_ready or (rec_ready ##1 rec_byte == iosm_pkg::BLK_TYPE[7:0])))
		else $error("block type wrong");
	chk_version: assert property ((rec_valid && beats_q == 6'h04) |-> rec_byte == iosm_pkg::VER_HI) else $error("version high wrong");
	chk_user_struct: assert property (
		(rec_valid && beats_q == 6'h1a) |-> rec_byte == iosm_pkg::USER_STRUCT[15:8])
		else $error("user struct id wrong");
	chk_stn_bits: assert property (
		##1 station_diag[iosm_pkg::SD_EXT_ERR] == $past(ext_error) && station_diag[2] == 1'b0)
		else $error("station diag wrong");
endmodule : iosm_top
`default_nettype wire

// [sim/iosm_reader.sv]
/*
 * iosm_reader: controller side that drains diagnostics records byte by byte.
 * assumes: a byte is offered with rec_valid and taken at an edge with rec_ready.
 */
`timescale 1ns/1ns
`default_nettype none
module iosm_reader (
	input  wire logic       mclk,
	input  wire logic       rec_valid,
	input  wire logic [7:0] rec_byte,
	input  wire logic       rec_last,
	input  wire logic       slow,
	output logic            rec_ready
);
	logic [7:0] got [0:33];
	int         idx = 0;
	int         len = 0;
	int         nrec = 0;
	// ----
	// take bytes, stall every other cycle when slow
	// ----
	initial rec_ready = 1'b0;
	always @(posedge mclk)
	begin
		if (rec_valid && rec_ready)
		begin
			if (idx < 34)
				got[idx] = rec_byte;
			len = idx + 1;
			idx = rec_last ? 0 : idx + 1;
			nrec = nrec + (rec_last ? 1 : 0);
		end
		#2 rec_ready = slow ? ~rec_ready : 1'b1;
	end
endmodule : iosm_reader
`default_nettype wire

// [sim/tb_top.sv]
/*
 * tb_top: self-checking bench for the port status mapper and record builder.
 * assumes: iosm_pkg, iosm_top and iosm_reader are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic        mclk = 1'b0;
	logic        arst_n = 1'b0;
	logic        slow = 1'b1;
	logic [7:0]  in_p4, in_p2, diag_in_p2, diag_in_en, out_cmd_p4, out_cmd_p2, short_gnd_p4;
	logic [7:0]  short_gnd_p2, volt_fb_p4, volt_fb_p2, restart_p4, restart_p2, sensor_short;
	logic        manual_restart, link_short, ext_error, actuator_supply_fault, sensor_supply_fault;
	logic [15:0] slot_num, subslot_num, alarm_spec, chan_props, chan_err_type;
	logic [63:0] module_id;
	logic        rec_ready, rec_pending, rec_valid, rec_last;
	logic [7:0]  in_img_p4, in_img_p2, out_img_p4, out_img_p2, drive_p4, drive_p2, rec_byte;
	logic [7:0]  shutdown_p4, shutdown_p2, warning_p4, warning_p2, periph_err, station_diag;
	int          errors = 0;
	int          checks_done = 0;
	int          cycles = 0;

	iosm_top dut (.mclk, .arst_n, .in_p4, .in_p2, .diag_in_p2, .diag_in_en, .out_cmd_p4, .out_cmd_p2,
		.short_gnd_p4, .short_gnd_p2, .volt_fb_p4, .volt_fb_p2, .manual_restart, .restart_p4,
		.restart_p2, .sensor_short, .link_short, .ext_error, .actuator_supply_fault,
		.sensor_supply_fault, .slot_num, .subslot_num, .module_id, .alarm_spec, .chan_props,
		.chan_err_type, .rec_ready, .in_img_p4, .in_img_p2, .out_img_p4, .out_img_p2, .drive_p4,
		.drive_p2, .shutdown_p4, .shutdown_p2, .warning_p4, .warning_p2, .periph_err,
		.station_diag, .rec_pending, .rec_valid, .rec_byte, .rec_last);
	iosm_reader rdr (.mclk, .rec_valid, .rec_byte, .rec_last, .slow, .rec_ready);

	always #20 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			errors++;
			close_out();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask : cyc

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out

	// whole record against the field layout, channel given
	task automatic wait_rec(input int n, input logic [15:0] ch);
		int          k = 0;
		logic [271:0] e;
		while (rdr.nrec < n && k < 400)
		begin
			cyc(1);
			k++;
		end
		chk("records", 8'(rdr.nrec), 8'(n));
		chk("length", 8'(rdr.len), 8'h22);
		e = {16'h0002, 16'h001e, 8'h01, 8'h00, 16'h0001, 32'h0, slot_num, subslot_num, module_id,
			alarm_spec, 16'h8000, ch, chan_props, chan_err_type};
		for (int i = 0; i < 34; i++)
			chk("rec byte", rdr.got[i], e[271 - 8 * i -: 8]);
	endtask : wait_rec

	task automatic t_images;
		in_p4 = 8'h81;
		in_p2 = 8'h42;
		diag_in_p2 = 8'h0f;
		diag_in_en = 8'h03;
		out_cmd_p4 = 8'ha5;
		out_cmd_p2 = 8'h5a;
		cyc(1);
		chk("in_img_p4", in_img_p4, 8'h81);
		chk("in_img_p2", in_img_p2, 8'h43);
		chk("out_img_p4", out_img_p4, 8'ha5);
		chk("out_img_p2", out_img_p2, 8'h5a);
		out_cmd_p4 = 8'h00;
		out_cmd_p2 = 8'h00;
		cyc(1);
		$display("images done");
	endtask : t_images

	task automatic t_short;
		manual_restart = 1'b1;
		out_cmd_p4 = 8'h08;
		short_gnd_p4 = 8'h08;
		cyc(1);
		chk("shutdown_p4", shutdown_p4, 8'h08);
		chk("periph_err", periph_err, 8'h08);
		chk("station_diag", station_diag, 8'h20);
		short_gnd_p4 = 8'h00;
		cyc(3);
		chk("held off", shutdown_p4, 8'h08);
		chk("drive_p4", drive_p4, 8'h00);
		restart_p4 = 8'h08;
		cyc(1);
		restart_p4 = 8'h00;
		chk("restarted", shutdown_p4, 8'h00);
		wait_rec(1, 16'h0003);
		chk("drive_p4", drive_p4, 8'h08);
		$display("short done");
	endtask : t_short

	task automatic t_warn;
		slow = 1'b0;
		volt_fb_p2 = 8'h20;
		sensor_short = 8'h01;
		{link_short, ext_error, actuator_supply_fault, sensor_supply_fault} = 4'hf;
		cyc(1);
		chk("warning_p2", warning_p2, 8'h20);
		chk("periph_err", periph_err, 8'h21);
		chk("station_diag", station_diag, 8'hdb);
		chk("rec_pending", {7'h00, rec_pending}, 8'h01);
		wait_rec(2, 16'h0000);
		$display("warning done");
	endtask : t_warn

	// pin 2 short with automatic restart
	task automatic t_auto;
		{volt_fb_p2, sensor_short} = '0;
		{link_short, ext_error, actuator_supply_fault, sensor_supply_fault} = 4'h0;
		manual_restart = 1'b0;
		out_cmd_p2 = 8'h10;
		short_gnd_p2 = 8'h10;
		cyc(1);
		chk("shutdown_p2", shutdown_p2, 8'h10);
		chk("drive_p2", drive_p2, 8'h00);
		chk("periph_err", periph_err, 8'h10);
		chk("station_diag", station_diag, 8'h20);
		chk("rec_pending", {7'h00, rec_pending}, 8'h01);
		short_gnd_p2 = 8'h00;
		cyc(1);
		chk("auto restart", shutdown_p2, 8'h00);
		chk("drive_p2", drive_p2, 8'h10);
		wait_rec(3, 16'h0004);
		$display("auto restart done");
	endtask : t_auto

	initial
	begin
		{in_p4, in_p2, diag_in_p2, diag_in_en, out_cmd_p4, out_cmd_p2, short_gnd_p4} = '0;
		{short_gnd_p2, volt_fb_p4, volt_fb_p2, restart_p4, restart_p2, sensor_short} = '0;
		{manual_restart, link_short, ext_error, actuator_supply_fault, sensor_supply_fault} = '0;
		slot_num = 16'h0010;
		subslot_num = 16'h0001;
		module_id = 64'h0123_4567_89ab_cdef;
		alarm_spec = 16'h1236;
		chan_props = 16'h0800;
		chan_err_type = 16'h001a;
		cyc(12);
		arst_n = 1'b1;
		cyc(1);
		t_images();
		t_short();
		t_warn();
		t_auto();
		close_out();
	end
endmodule : tb_top
`default_nettype wire
